// [hdl/pwt_pkg.sv]
/*
  Shared constants and types for the periodic wakeup timer.
  Assumes a 100 MHz pclk and an 8-bit APB address slice.
*/
package pwt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking and internal oscillator timing
  localparam int PWT_CLK_PERIOD_NS = 10;
  localparam int PWT_OSC_PERIOD_NS = 1000000;  // about 1 kHz
  localparam int PWT_OSC_CYCLES = PWT_OSC_PERIOD_NS / PWT_CLK_PERIOD_NS;
  localparam int PWT_OSC_CNT_W = 17;
  localparam int PWT_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register map and field positions
  localparam logic [7:0] PWT_CTRL_OFFSET = 8'h00;
  localparam int PWT_FLAG_BIT = 7;
  localparam int PWT_ACK_BIT = 6;
  localparam int PWT_CLKS_BIT = 5;
  localparam int PWT_IE_BIT = 4;
  localparam int PWT_SEL_LSB = 0;
  localparam int PWT_SEL_MSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // period tables, indexed by delay select; entry 0 means stopped
  localparam logic [15:0] PWT_INT_MS [8] = '{16'h0000, 16'h0008, 16'h0020,
    16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400};
  localparam logic [15:0] PWT_EXT_DIV [8] = '{16'h0000, 16'h0100, 16'h0400,
    16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h8000};

  // bus phase, one-hot
  typedef enum logic [1:0] {
    PWT_BUS_IDLE = 2'b01,
    PWT_BUS_READY = 2'b10
  } pwt_bus_t;

  typedef struct packed {
    logic flag;
    logic clks;
    logic ie;
    logic [2:0] sel;
    logic [PWT_CNT_W-1:0] cnt;
    pwt_bus_t bus;
    logic [31:0] rdata;
    logic slverr;
    logic irq;
    logic wake;
    logic active;
  } pwt_top_state_t;

  localparam pwt_top_state_t PWT_TOP_RST = '{flag: 1'b0, clks: 1'b0, ie: 1'b0,
    sel: 3'h0, cnt: 16'h0000, bus: PWT_BUS_IDLE, rdata: 32'h0000_0000,
    slverr: 1'b0, irq: 1'b0, wake: 1'b0, active: 1'b0};

  // ticks per timeout for a delay select and clock source
  function automatic logic [15:0] pwt_target(input logic [2:0] sel, input logic clks);
    return clks ? PWT_EXT_DIV[sel] : PWT_INT_MS[sel];
  endfunction : pwt_target

  function automatic logic pwt_hit(input logic [7:0] addr);
    return addr == PWT_CTRL_OFFSET;
  endfunction : pwt_hit

endpackage : pwt_pkg

// [hdl/pwt_sync.sv]
/*
  Three-stage synchroniser with agreement filter and rising-edge pulse.
  Assumes din is asynchronous to pclk and slower than pclk / 4.
*/
`timescale 1ns/100ps
module pwt_sync
  import pwt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic din,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } pwt_sync_state_t;

  pwt_sync_state_t st_reg, st_next;

  ////////////////////////////////////////////////////////////////////////////
  // s1 feeds only s2; the filter waits for s2 and s3 to agree
  always_comb begin
    st_next = st_reg;
    // the pulse is frozen with the rest, so a tick is not lost in a stall
    if (pclk_en) begin
      st_next.rise = 1'b0;
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
        st_next.lvl = st_reg.s3;
        st_next.rise = st_reg.s3 & ~st_reg.lvl;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;
  assign rise = st_reg.rise;

endmodule : pwt_sync

// [hdl/pwt_osc.sv]
/*
  Free-running 1 kHz tick source standing in for the self-clocked oscillator.
  Assumes pclk keeps running; nothing but reset and pclk_en touches it.
*/
`timescale 1ns/100ps
module pwt_osc
  import pwt_pkg::*;
#(
  parameter int TICK_CYCLES = PWT_OSC_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  output logic tick
);

  localparam logic [PWT_OSC_CNT_W-1:0] LAST = PWT_OSC_CNT_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [PWT_OSC_CNT_W-1:0] cnt;
    logic tick;
  } pwt_osc_state_t;

  pwt_osc_state_t st_reg, st_next;

  ////////////////////////////////////////////////////////////////////////////
  // not gated by source select or stop modes, so it is independent
  always_comb begin
    st_next = st_reg;
    if (pclk_en) begin
      st_next.tick = (st_reg.cnt == LAST);
      st_next.cnt = (st_reg.cnt == LAST) ? '0 : st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  osc_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.tick && pclk_en && TICK_CYCLES > 1) |=> !st_reg.tick)
    else $error("oscillator tick longer than one cycle");

endmodule : pwt_osc

// [hdl/pwt_top.sv]
/*
  Periodic wakeup timer: one control/status register on APB, internal
  1 kHz or external clock source, timeout flag, interrupt and stop wake.
  Assumes stop-mode and osc_run_in_stop levels come from pclk-domain logic;
  ext_clk_pin is asynchronous and much slower than pclk.
*/
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps

module pwt_top
  import pwt_pkg::*;
#(
  parameter int OSC_TICK_CYCLES = PWT_OSC_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_pin,
  input wire logic osc_run_in_stop,
  input wire logic deep_stop_mode,
  input wire logic light_stop_mode,
  output logic wakeup_irq,
  output logic stop_wake,
  output logic timer_active
);

  pwt_top_state_t st_reg, st_next;

  logic ext_rise;
  logic osc_tick;
  logic bus_done;
  logic wr_hit;
  logic run_ok;
  logic tick_src;
  logic fire;
  logic [PWT_CNT_W-1:0] target;
  logic [PWT_CNT_W-1:0] cnt_inc;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // tick sources

  // the crystal clock is an asynchronous pin, so it goes through the filter
  pwt_sync pwt_sync_inst (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .din(ext_clk_pin),
    .level(),
    .rise(ext_rise)
  );

  pwt_osc #(
    .TICK_CYCLES(OSC_TICK_CYCLES)
  ) pwt_osc_inst (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .tick(osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // a transfer completes only when pready is seen high in the access phase
  assign bus_done = psel && penable && pready;
  assign wr_hit = bus_done && pwrite && pwt_hit(paddr);

  // read word built from the live fields; bits 6 and 3 and above 7 stay zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_word[PWT_FLAG_BIT] = st_reg.flag;
    rd_word[PWT_CLKS_BIT] = st_reg.clks;
    rd_word[PWT_IE_BIT] = st_reg.ie;
    rd_word[PWT_SEL_MSB:PWT_SEL_LSB] = st_reg.sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting

  // external source keeps running in light stop only with the oscillator on
  assign run_ok = !(deep_stop_mode && st_reg.clks)
    && !(light_stop_mode && st_reg.clks && !osc_run_in_stop);
  assign tick_src = st_reg.clks ? ext_rise : osc_tick;
  assign target = pwt_target(st_reg.sel, st_reg.clks);
  assign cnt_inc = st_reg.cnt + 16'h0001;

  // >= rather than == so a shorter select written mid-count still fires soon
  assign fire = pclk_en && (st_reg.sel != 3'h0) && run_ok && tick_src
    && (cnt_inc >= target);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // everything freezes while pclk_en is low, the bus handshake included
  always_comb begin
    st_next = st_reg;
    if (pclk_en) begin
      // zero select holds the count at zero so a restart begins cleanly
      if (st_reg.sel == 3'h0) begin
        st_next.cnt = 16'h0000;
      end else if (run_ok && tick_src) begin
        st_next.cnt = fire ? 16'h0000 : cnt_inc;
      end

      // acknowledge first, then a timeout in the same cycle wins
      if (wr_hit && pwdata[PWT_ACK_BIT]) begin
        st_next.flag = 1'b0;
      end
      if (fire) begin
        st_next.flag = 1'b1;
      end

      // writable control fields
      if (wr_hit) begin
        st_next.clks = pwdata[PWT_CLKS_BIT];
        st_next.ie = pwdata[PWT_IE_BIT];
        st_next.sel = pwdata[PWT_SEL_MSB:PWT_SEL_LSB];
      end

      // a stop written now clears the count at once, not one edge later
      if (st_next.sel == 3'h0) begin
        st_next.cnt = 16'h0000;
      end

      // read data are caught before the access phase so prdata is a flop
      case (st_reg.bus)
        PWT_BUS_IDLE: begin
          if (psel) begin
            st_next.bus = PWT_BUS_READY;
            st_next.rdata = pwt_hit(paddr) ? rd_word : 32'h0000_0000;
            st_next.slverr = !pwt_hit(paddr);
          end
        end
        PWT_BUS_READY: begin
          if (bus_done || !psel) begin
            st_next.bus = PWT_BUS_IDLE;
          end
        end
        default: begin
          st_next.bus = PWT_BUS_IDLE;
        end
      endcase

      // request held as long as flag and enable are both set
      st_next.irq = st_next.flag && st_next.ie;
      // any stop mode, the deepest included, is left on a timer request
      st_next.wake = st_next.irq && (deep_stop_mode || light_stop_mode);
      st_next.active = (st_next.sel != 3'h0) && run_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= PWT_TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait once read data are latched; stretched only by pclk_en
  assign pready = pclk_en && (st_reg.bus == PWT_BUS_READY);
  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.slverr;
  assign wakeup_irq = st_reg.irq;
  assign stop_wake = st_reg.wake;
  assign timer_active = st_reg.active;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking pwt_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a timeout shows in the flag at the next edge
  flag_set_a: assert property (fire |=> st_reg.flag)
    else $error("timeout did not set the flag");

  // acknowledge clears unless a timeout lands in the same cycle
  ack_clear_a: assert property (
    (wr_hit && pclk_en && pwdata[PWT_ACK_BIT] && !fire) |=> !st_reg.flag)
    else $error("acknowledge did not clear the flag");

  // flag never drops without an acknowledge write
  flag_hold_a: assert property (
    (st_reg.flag && !(wr_hit && pwdata[PWT_ACK_BIT])) |=> st_reg.flag)
    else $error("flag dropped without acknowledge");

  // acknowledge bit and unimplemented bits read back as zero
  read_zero_a: assert property (
    (bus_done && !pwrite) |-> (prdata[31:8] == 24'h000000) && !prdata[PWT_ACK_BIT]
      && !prdata[3])
    else $error("reserved or acknowledge bit read as one");

  // writes land in the source select and the delay select
  ctrl_write_a: assert property (
    (wr_hit && pclk_en) |=> (st_reg.clks == $past(pwdata[PWT_CLKS_BIT]))
      && (st_reg.sel == $past(pwdata[PWT_SEL_MSB:PWT_SEL_LSB])))
    else $error("control write not stored");

  // interrupt request needs the enable
  irq_gate_a: assert property (!st_reg.ie |-> !wakeup_irq)
    else $error("interrupt raised while disabled");

  // a raised request stays until acknowledged or disabled
  irq_hold_a: assert property (
    (wakeup_irq && !wr_hit) |=> wakeup_irq)
    else $error("interrupt request dropped early");

  // request follows a fresh timeout within two edges when enabled
  irq_rise_a: assert property (
    (fire && st_reg.ie && !wr_hit) |-> ##[1:2] wakeup_irq)
    else $error("timeout with enable raised no request");

  // zero select never times out and holds the count at zero
  sel_off_a: assert property (
    (st_reg.sel == 3'h0) |-> !fire && (st_reg.cnt == 16'h0000))
    else $error("stopped timer counted or fired");

  // reaching the tabled count on a running tick must time out; a shorter select
  // written mid-count may fire past it, so only the exact end point is pinned
  period_a: assert property (
    (pclk_en && run_ok && tick_src && (st_reg.sel != 3'h0) && (cnt_inc == target))
      |-> fire)
    else $error("timeout missed at the tabled count");

  // count restarts from zero after each timeout
  restart_a: assert property (fire |=> st_reg.cnt == 16'h0000)
    else $error("count did not restart after timeout");

  // external source is frozen in deep stop
  deep_stop_a: assert property (
    (deep_stop_mode && st_reg.clks) |-> !fire)
    else $error("external source ran in deep stop");

  // external source in light stop needs the oscillator kept on
  light_stop_a: assert property (
    (light_stop_mode && st_reg.clks && !osc_run_in_stop) |-> !fire)
    else $error("external source ran in light stop without oscillator");

  // an interrupt in deep stop raises the wake request next edge
  deep_wake_a: assert property (
    (pclk_en && wakeup_irq && deep_stop_mode && !wr_hit) |=> stop_wake)
    else $error("no wake from deep stop on timer request");

  // a pending request in light stop raises the wake request as well
  light_wake_a: assert property (
    (pclk_en && wakeup_irq && light_stop_mode && !wr_hit) |=> stop_wake)
    else $error("no wake from light stop on timer request");

  // outside the stop modes nothing asks for a wake
  no_wake_a: assert property (
    (pclk_en && !deep_stop_mode && !light_stop_mode) |=> !stop_wake)
    else $error("wake request outside stop modes");

  ////////////////////////////////////////////////////////////////////////////
  // period tables and source gating, checked against the doubling rule

  // a timeout only ever lands on a tick of a source that may run
  fire_tick_a: assert property (fire |-> tick_src && run_ok)
    else $error("timeout without a running tick");

  // internal periods: code 1 is 8 ticks, then powers of two from 32
  int_table_a: assert property (
    (!st_reg.clks && (st_reg.sel != 3'h0)) |-> ((st_reg.sel == 3'h1) ? (target == 16'h0008)
      : (target == (16'h0001 << ({1'b0, st_reg.sel} + 4'h3)))))
    else $error("internal period off the table");

  // external dividers: code 1 is 256, then powers of two from 1024
  ext_table_a: assert property (
    (st_reg.clks && (st_reg.sel != 3'h0)) |-> ((st_reg.sel == 3'h1) ? (target == 16'h0100)
      : (target == (16'h0001 << ({1'b0, st_reg.sel} + 4'h8)))))
    else $error("external divider off the table");

  // a stopped timer never reports itself active
  active_off_a: assert property ((st_reg.sel == 3'h0) |-> !timer_active)
    else $error("stopped timer reported active");

  // the internal source runs whatever the stop levels say
  int_run_a: assert property (
    (pclk_en && !st_reg.clks && (st_reg.sel != 3'h0) && !wr_hit) |=> timer_active)
    else $error("internal source gated by a stop mode");

  // the crystal keeps the timer running in light stop when kept on
  light_run_a: assert property (
    (pclk_en && st_reg.clks && light_stop_mode && osc_run_in_stop && !deep_stop_mode
      && (st_reg.sel != 3'h0) && !wr_hit) |=> timer_active)
    else $error("external source stopped in light stop with oscillator on");

  ////////////////////////////////////////////////////////////////////////////
  // clock enable and bus phase

  // a low clock enable holds every field, the bus phase included
  freeze_a: assert property (!pclk_en |=> (st_reg == $past(st_reg)))
    else $error("state moved while clock enable was low");

  // no transfer completes while the clock enable is low
  stall_ready_a: assert property (!pclk_en |-> !pready)
    else $error("ready raised during a stall");

  // an enabled setup cycle always moves the bus to its answer phase
  setup_ready_a: assert property (
    (pclk_en && psel && !penable && (st_reg.bus == PWT_BUS_IDLE)) |=> (st_reg.bus == PWT_BUS_READY))
    else $error("setup cycle did not reach the answer phase");

  // latched read data stand through the answer phase
  rdata_hold_a: assert property (
    (st_reg.bus == PWT_BUS_READY) |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved during the answer phase");

  // an unmapped address answers with an error and zero data
  unmapped_err_a: assert property (
    (bus_done && !pwt_hit(paddr)) |-> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access answered without error");

  // main scenarios: each source times out, a timeout races an acknowledge, a wake is raised

  ext_fire_c: cover property (fire && st_reg.clks);
  int_fire_c: cover property (fire && !st_reg.clks && deep_stop_mode);
  ack_race_c: cover property (fire && wr_hit && pwdata[PWT_ACK_BIT]);
  wake_c: cover property (stop_wake);
  light_ext_c: cover property (fire && st_reg.clks && light_stop_mode && osc_run_in_stop);

endmodule : pwt_top

// [verification/pwt_bench.sv]
/*
  Self-checking bench for the periodic wakeup timer top: register fields,
  both clock sources, stop gating, wake requests and APB stalls.
  Assumes pwt_top from pwt_pkg, a 4-cycle oscillator tick and APB at 0x00.
*/
`timescale 1ns/100ps
module pwt_bench import pwt_pkg::*;;
  localparam int TICK = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pclk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext_clk_pin = 1'b0;
  logic osc_run_in_stop = 1'b0;
  logic deep_stop_mode = 1'b0;
  logic light_stop_mode = 1'b0;
  logic ext_run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wakeup_irq;
  logic stop_wake;
  logic timer_active;
  logic [31:0] rd_s;
  logic er_s;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int ext_div = 0;
  int rises = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, cycle count and a slow crystal stand-in (period 12 pclk)
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (ext_run) begin
      ext_div <= (ext_div == 5) ? 0 : ext_div + 1;
      if (ext_div == 5) ext_clk_pin <= ~ext_clk_pin;
    end
  end
  // bench's own count of crystal edges, independent of the synchroniser
  always @(posedge ext_clk_pin) rises++;

  pwt_top #(.OSC_TICK_CYCLES(TICK)) pwt_top_inst (.pclk(pclk), .presetn(presetn),
    .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(ext_clk_pin), .osc_run_in_stop(osc_run_in_stop),
    .deep_stop_mode(deep_stop_mode), .light_stop_mode(light_stop_mode),
    .wakeup_irq(wakeup_irq), .stop_wake(stop_wake), .timer_active(timer_active));

  ////////////////////////////////////////////////////////////////////////////
  // comparison, expectations and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] exp_reg(input logic f, c, ie, input logic [2:0] s);
    return {24'h00_0000, f, 1'b0, c, ie, 1'b0, s};
  endfunction : exp_reg

  // the crystal source is frozen in deep stop, and in light stop unless kept running
  function automatic logic exp_active(input logic c, dp, lt, osc, input logic [2:0] s);
    return (s != 3'h0) && (!c || (!dp && (!lt || osc)));
  endfunction : exp_active

  // stall holds pclk_en low through the first access cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input int stall, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (stall > 0) pclk_en <= 1'b0;
    repeat (stall) begin
      @(posedge pclk);
      check("stalled pready", {31'h0, pready}, 32'h0);
    end
    pclk_en <= 1'b1;
    // no cycle count is assumed; only the watchdog ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check("apb answer", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] d);
    apb(1'b1, PWT_CTRL_OFFSET, {24'h00_0000, d}, 0, rd_s, er_s);
  endtask : wr

  task automatic rd_reg(output logic [31:0] v);
    apb(1'b0, PWT_CTRL_OFFSET, 32'h0000_0000, 0, v, er_s);
  endtask : rd_reg

  // skip one edge first so a write landing now is seen
  task automatic wait_irq(input logic want);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wakeup_irq !== want && n < 40000);
    check("irq level", {31'h0, wakeup_irq}, {31'h0, want});
  endtask : wait_irq

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, about three times the expected run
  initial begin
    #1_000_000;
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] v;
    logic e;
    logic [7:0] r;
    int t0;
    void'($urandom(26));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_reg(v);
    check("reset value", v, 32'h0);
    check("mapped err", {31'h0, er_s}, 32'h0);
    apb(1'b0, 8'($urandom_range(255, 1)), 32'h0, 0, v, e);
    check("unmapped data", v, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    // field readback with the select held at zero so no timeout interferes
    repeat (12) begin
      r = 8'($urandom);
      wr({r[7:3], 3'h0});
      apb(1'b0, PWT_CTRL_OFFSET, 32'h0, 3, v, e);
      check("readback", v, exp_reg(1'b0, r[5], r[4], 3'h0));
    end
    // every internal period, measured between two consecutive timeouts
    for (int i = 1; i < 8; i++) begin
      wr(8'h40);
      wr(8'h10 | 8'(i));
      wait_irq(1'b1);
      t0 = cyc;
      rd_reg(v);
      check("flag set", v, exp_reg(1'b1, 1'b0, 1'b1, 3'(i)));
      wr(8'h50 | 8'(i));
      wait_irq(1'b1);
      check("int period", 32'(cyc - t0), 32'(TICK * PWT_INT_MS[i]));
    end
    // disabled requests stay low while the flag still sets
    wr(8'h40);
    wr(8'h01);
    repeat (48) begin
      @(posedge pclk);
      check("masked irq", {31'h0, wakeup_irq}, 32'h0);
    end
    wr(8'h01);
    rd_reg(v);
    check("ack zero", v, exp_reg(1'b1, 1'b0, 1'b0, 3'h1));
    wr(8'h40);
    rd_reg(v);
    check("ack one", v, exp_reg(1'b0, 1'b0, 1'b0, 3'h0));
    // wake request from deep stop while a request is pending
    wr(8'h11);
    wait_irq(1'b1);
    deep_stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    check("deep wake", {31'h0, stop_wake}, 32'h1);
    deep_stop_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    check("no wake", {31'h0, stop_wake}, 32'h0);
    // external source: timeout after the documented count of crystal edges
    ext_run <= 1'b1;
    for (int i = 1; i < 3; i++) begin
      wr(8'h40);
      wr(8'h30 | 8'(i));
      rises = 0;
      wait_irq(1'b1);
      check("ext count",
            {31'h0, (rises + 1 >= PWT_EXT_DIV[i]) && (rises <= PWT_EXT_DIV[i] + 1)}, 32'h1);
    end
    // random source, select and stop levels against the run gating
    repeat (24) begin
      r = 8'($urandom);
      wr({2'b00, r[5], 2'b00, r[2:0]});
      deep_stop_mode <= r[7];
      light_stop_mode <= r[6];
      osc_run_in_stop <= r[3];
      repeat (2) @(posedge pclk);
      check("active", {31'h0, timer_active},
            {31'h0, exp_active(r[5], r[7], r[6], r[3], r[2:0])});
    end
    deep_stop_mode <= 1'b0;
    light_stop_mode <= 1'b0;
    // reset in mid-run clears the register
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_reg(v);
    check("rerun reset", v, 32'h0);
    stop_test();
  end
endmodule : pwt_bench
